// [acr_pkg.sv]
`default_nettype none
package acr_pkg;
    // ==========================================================
    // Register map (word index on the plain register port)
    localparam logic [2:0] ACR_OFS_PIN_SELECT = 3'h0;
    localparam logic [2:0] ACR_OFS_CONTROL = 3'h1;
    localparam logic [2:0] ACR_OFS_OFFSET_TRIM = 3'h2;
    localparam logic [2:0] ACR_OFS_RESULT_HIGH = 3'h3;
    localparam logic [2:0] ACR_OFS_RESULT_LOW = 3'h4;
    localparam logic [2:0] ACR_OFS_STATUS = 3'h5;

    // ==========================================================
    // Field positions
    localparam int ACR_CTL_DIV_LSB = 5;
    localparam int ACR_CTL_RUN_BIT = 4;
    localparam int ACR_CTL_PWR_BIT = 3;
    localparam int ACR_TRIM_EN_BIT = 7;
    localparam int ACR_TRIM_SIGN_BIT = 6;
    localparam int ACR_TRIM_MAG_LSB = 3;
    localparam int ACR_STAT_DONE_BIT = 0;
    localparam int ACR_STAT_RSTTYPE_BIT = 7;

    // ==========================================================
    // Reset values
    localparam logic [6:0] ACR_PIN_SELECT_RST = 7'h00;
    localparam logic [1:0] ACR_DIV_RST = 2'h0;
    localparam logic [2:0] ACR_CHANNEL_RST = 3'h0;
    localparam logic [2:0] ACR_TRIM_RST = 3'h0;
    localparam logic [11:0] ACR_RESULT_RST = 12'h000;

    // ==========================================================
    // Channel codes and converter clock divisors
    localparam logic [2:0] ACR_CH_NONE = 3'h7;
    localparam logic [2:0] ACR_CH_OSC_IN = 3'h6;
    localparam logic [2:0] ACR_CH_OSC_OUT = 3'h5;
    localparam logic [2:0] ACR_CH_INFRARED = 3'h4;
    localparam logic [6:0] ACR_DIV_CODE0 = 7'h10;
    localparam logic [6:0] ACR_DIV_CODE1 = 7'h04;
    localparam logic [6:0] ACR_DIV_CODE2 = 7'h40;
    localparam logic [6:0] ACR_DIV_CODE3 = 7'h08;

    typedef enum logic [0:0] {
        ACR_IDLE = 1'b0,
        ACR_RUN = 1'b1
    } acr_run_state_t;

    // Requests toward the analog converter core
    typedef struct packed {
        logic start;
        logic clk_tick;
        logic power_on;
        logic [2:0] channel;
        logic channel_valid;
    } acr_conv_req_t;

    // Answer from the analog converter core
    typedef struct packed {
        logic done;
        logic [11:0] data;
    } acr_conv_res_t;
endpackage
`default_nettype wire

// [acr_clk_div.sv]
`timescale 1ns/10ps
`default_nettype none
module acr_clk_div (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Divider choice
    input wire logic [1:0] div_sel_in,
    // One-cycle tick at the converter rate
    output logic tick_out
);
    import acr_pkg::*;

    logic [6:0] count_reg;
    logic [6:0] count_next;
    logic [1:0] sel_reg;
    logic tick_reg;
    logic tick_next;
    logic [6:0] divisor;

    // ==========================================================
    // Divisor decode and count
    always_comb begin
        case (div_sel_in)
            2'h0: divisor = ACR_DIV_CODE0;
            2'h1: divisor = ACR_DIV_CODE1;
            2'h2: divisor = ACR_DIV_CODE2;
            2'h3: divisor = ACR_DIV_CODE3;
            default: divisor = ACR_DIV_CODE0;
        endcase
        // A new divisor restarts the count so no short period slips out
        tick_next = 1'b0;
        if (div_sel_in != sel_reg) begin
            count_next = 7'h00;
        end else if (count_reg == divisor - 7'h01) begin
            count_next = 7'h00;
            tick_next = 1'b1;
        end else begin
            count_next = count_reg + 7'h01;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            count_reg <= 7'h00;
            sel_reg <= ACR_DIV_RST;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            sel_reg <= div_sel_in;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;
endmodule // acr_clk_div
`default_nettype wire

// [acr_offset_corr.sv]
`timescale 1ns/10ps
`default_nettype none
module acr_offset_corr (
    // Raw sample and trim settings
    input wire logic [11:0] raw_in,
    input wire logic enable_in,
    input wire logic sign_in,
    input wire logic [2:0] magnitude_in,
    // Corrected sample
    output logic [11:0] corrected_out
);
    import acr_pkg::*;

    logic [12:0] step;
    logic [12:0] sum;

    // ==========================================================
    // Offset is twice the code in LSBs; result saturates at the rails
    always_comb begin
        step = {9'h000, magnitude_in, 1'b0};
        sum = {1'b0, raw_in};
        if (enable_in) begin
            if (sign_in) begin
                sum = {1'b0, raw_in} + step;
            end else begin
                sum = {1'b0, raw_in} - step;
            end
        end
        if (enable_in && sign_in && sum[12]) begin
            corrected_out = 12'hfff;
        end else if (enable_in && !sign_in && sum[12]) begin
            corrected_out = 12'h000;
        end else begin
            corrected_out = sum[11:0];
        end
    end
endmodule // acr_offset_corr
`default_nettype wire

// [acr_control.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Seven pin-select bits each make a shared pin analog (1) or digital (0)
// - Bit 6 pin 5.5, bit 5 pin 7.0, bit 4 pin 6.7, bits 3..0 pins 5.3..5.0
// - Oscillator input beats analog beats port on pin 5.5; code 6 unused then
// - Oscillator output beats analog beats port on pin 7.0; code 5 unused then
// - Pin 6.7: analog beats infrared beats port; never both at once
// - Two-bit divider field: 00 /16, 01 /4, 10 /64, 11 /8
// - Writing one to run bit 4 starts a conversion; bit stays high meanwhile
// - Hardware clears run bit on completion; writing zero does nothing
// - Power bit 3 keeps converter and reference on; zero switches reference off
// - Codes 000..110 route channels 0..6; code 111 selects nothing
// - Channel field changes only while done flag and run bit are both low
// - Offset correction applies only while trim enable bit 7 is one
// - Trim bit 6 is polarity: zero negative, one positive
// - Trim bits 5..3 give offset of twice the code in LSBs
// - Trim bits 2..0 read as zero
// - Reset-type bit set on wake by pin, comparator or conversion; else cleared
// - Done flag set on completion; software clears only, never sets
// - Completion loads 12-bit result, clears run, sets done; high byte top nibble zero
module acr_control (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Converter core
    output acr_pkg::acr_conv_req_t conv_req_out,
    input wire acr_pkg::acr_conv_res_t conv_res_in,
    // Pin function sources
    input wire logic osc_in_mode_in,
    input wire logic osc_out_mode_in,
    input wire logic infrared_output_enable_in,
    // Pin function results
    output logic [6:0] pin_analog_out,
    output logic infrared_drive_out,
    // Sleep and wake events
    input wire logic sleep_in,
    input wire logic wake_pin_change_in,
    input wire logic wake_comparator_in,
    input wire logic other_reset_in
);
    import acr_pkg::*;

    // ==========================================================
    // Register state
    logic [6:0] pin_select_reg;
    logic [6:0] pin_select_next;
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic power_reg;
    logic power_next;
    logic [2:0] channel_reg;
    logic [2:0] channel_next;
    logic trim_en_reg;
    logic trim_en_next;
    logic trim_sign_reg;
    logic trim_sign_next;
    logic [2:0] trim_mag_reg;
    logic [2:0] trim_mag_next;
    acr_run_state_t state_reg;
    acr_run_state_t state_next;
    logic start_reg;
    logic start_next;
    logic done_flag_reg;
    logic done_flag_next;
    logic reset_type_reg;
    logic reset_type_next;
    logic [11:0] result_reg;
    logic [11:0] result_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [11:0] corrected;
    logic div_tick;
    logic completion;
    logic running;

    function automatic logic hit(input logic [2:0] addr, input logic [2:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign running = (state_reg == ACR_RUN);
    // A done pulse outside a conversion is stray and dropped
    assign completion = running && conv_res_in.done;

    // ==========================================================
    // Submodules
    acr_clk_div u_div (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .div_sel_in(div_reg),
        .tick_out(div_tick)
    );

    acr_offset_corr u_corr (
        .raw_in(conv_res_in.data),
        .enable_in(trim_en_reg),
        .sign_in(trim_sign_reg),
        .magnitude_in(trim_mag_reg),
        .corrected_out(corrected)
    );

    // ==========================================================
    // Configuration writes
    always_comb begin
        pin_select_next = pin_select_reg;
        div_next = div_reg;
        power_next = power_reg;
        channel_next = channel_reg;
        trim_en_next = trim_en_reg;
        trim_sign_next = trim_sign_reg;
        trim_mag_next = trim_mag_reg;
        if (reg_wr_in && hit(reg_addr_in, ACR_OFS_PIN_SELECT)) begin
            pin_select_next = reg_wdata_in[6:0];
        end
        if (reg_wr_in && hit(reg_addr_in, ACR_OFS_CONTROL)) begin
            div_next = reg_wdata_in[ACR_CTL_DIV_LSB+:2];
            power_next = reg_wdata_in[ACR_CTL_PWR_BIT];
            // Input select is locked while a result is pending or running
            if (!done_flag_reg && !running) begin
                channel_next = reg_wdata_in[2:0];
            end
        end
        if (reg_wr_in && hit(reg_addr_in, ACR_OFS_OFFSET_TRIM)) begin
            trim_en_next = reg_wdata_in[ACR_TRIM_EN_BIT];
            trim_sign_next = reg_wdata_in[ACR_TRIM_SIGN_BIT];
            trim_mag_next = reg_wdata_in[ACR_TRIM_MAG_LSB+:3];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            pin_select_reg <= ACR_PIN_SELECT_RST;
            div_reg <= ACR_DIV_RST;
            power_reg <= 1'b0;
            channel_reg <= ACR_CHANNEL_RST;
            trim_en_reg <= 1'b0;
            trim_sign_reg <= 1'b0;
            trim_mag_reg <= ACR_TRIM_RST;
        end else begin
            pin_select_reg <= pin_select_next;
            div_reg <= div_next;
            power_reg <= power_next;
            channel_reg <= channel_next;
            trim_en_reg <= trim_en_next;
            trim_sign_reg <= trim_sign_next;
            trim_mag_reg <= trim_mag_next;
        end
    end

    // ==========================================================
    // Conversion sequencing, result and flags
    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        result_next = result_reg;
        done_flag_next = done_flag_reg;
        case (state_reg)
            ACR_IDLE: begin
                // Writing zero to the run bit is ignored
                if (reg_wr_in && hit(reg_addr_in, ACR_OFS_CONTROL)
                        && reg_wdata_in[ACR_CTL_RUN_BIT]) begin
                    state_next = ACR_RUN;
                    start_next = 1'b1;
                end
            end
            ACR_RUN: begin
                if (completion) begin
                    state_next = ACR_IDLE;
                    result_next = corrected;
                end
            end
            default: state_next = ACR_IDLE;
        endcase
        // Software clear by writing zero; a completion in that cycle wins
        if (reg_wr_in && hit(reg_addr_in, ACR_OFS_STATUS)
                && !reg_wdata_in[ACR_STAT_DONE_BIT]) begin
            done_flag_next = 1'b0;
        end
        if (completion) begin
            done_flag_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state_reg <= ACR_IDLE;
            start_reg <= 1'b0;
            result_reg <= ACR_RESULT_RST;
            done_flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
            result_reg <= result_next;
            done_flag_reg <= done_flag_next;
        end
    end

    // ==========================================================
    // Reset-type bit: wake events win over a clearing reset cause
    always_comb begin
        reset_type_next = reset_type_reg;
        if (other_reset_in) begin
            reset_type_next = 1'b0;
        end
        if (sleep_in && (wake_pin_change_in || wake_comparator_in || completion)) begin
            reset_type_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            reset_type_reg <= 1'b0;
        end else begin
            reset_type_reg <= reset_type_next;
        end
    end

    // ==========================================================
    // Read data, valid only in the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ACR_OFS_PIN_SELECT: rdata_next = {1'b0, pin_select_reg};
                ACR_OFS_CONTROL: rdata_next = {1'b0, div_reg, running,
                    power_reg, channel_reg};
                ACR_OFS_OFFSET_TRIM: rdata_next = {trim_en_reg, trim_sign_reg,
                    trim_mag_reg, 3'h0};
                ACR_OFS_RESULT_HIGH: rdata_next = {4'h0, result_reg[11:8]};
                ACR_OFS_RESULT_LOW: rdata_next = result_reg[7:0];
                ACR_OFS_STATUS: rdata_next = {reset_type_reg, 6'h00, done_flag_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // Pin function priority; blocked pins never reach the converter
    always_comb begin
        pin_analog_out = pin_select_reg;
        pin_analog_out[6] = pin_select_reg[6] && !osc_in_mode_in;
        pin_analog_out[5] = pin_select_reg[5] && !osc_out_mode_in;
        infrared_drive_out = infrared_output_enable_in && !pin_select_reg[4];
    end

    // ==========================================================
    // Converter requests
    always_comb begin
        conv_req_out.start = start_reg;
        conv_req_out.clk_tick = div_tick;
        conv_req_out.power_on = power_reg;
        conv_req_out.channel = channel_reg;
        // Code 111 and oscillator-held pins route nothing
        conv_req_out.channel_valid = (channel_reg != ACR_CH_NONE)
            && !(osc_in_mode_in && channel_reg == ACR_CH_OSC_IN)
            && !(osc_out_mode_in && channel_reg == ACR_CH_OSC_OUT);
    end

    assign reg_rdata_out = rdata_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    AST_RUN_ON_START: assert property (
        (!running && reg_wr_in && reg_addr_in == ACR_OFS_CONTROL
            && reg_wdata_in[ACR_CTL_RUN_BIT]) |=> (running && conv_req_out.start))
        else $error("run bit not set by start write");
    AST_RUN_HOLDS: assert property (
        (running && !conv_res_in.done) |=> running)
        else $error("run bit dropped without completion");
    AST_DONE_CLEARS_RUN: assert property (
        completion |=> (!running && done_flag_reg && result_reg == $past(corrected)))
        else $error("completion did not load result and flags");
    AST_FLAG_NO_SW_SET: assert property (
        (!done_flag_reg && !completion) |=> !done_flag_reg)
        else $error("done flag set without completion");
    AST_CHANNEL_LOCK: assert property (
        (done_flag_reg || running) |=> $stable(channel_reg))
        else $error("channel changed while locked");
    AST_TRIM_LOW_ZERO: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == ACR_OFS_OFFSET_TRIM
            |-> reg_rdata_out[2:0] == 3'h0)
        else $error("trim low bits not zero");
    AST_HIGH_NIBBLE: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == ACR_OFS_RESULT_HIGH
            |-> reg_rdata_out == {4'h0, $past(result_reg[11:8])})
        else $error("result high read wrong");
    AST_IR_EXCLUSIVE: assert property (
        !(pin_analog_out[4] && infrared_drive_out))
        else $error("pin used for analog and infrared");
    AST_OSC_PRIORITY: assert property (
        osc_in_mode_in |-> !pin_analog_out[6])
        else $error("oscillator pin taken as analog");
    AST_WAKE_SETS: assert property (
        (sleep_in && wake_pin_change_in) |=> reset_type_reg)
        else $error("reset type not set on wake");
    AST_NOSEL: assert property (
        channel_reg == ACR_CH_NONE |-> !conv_req_out.channel_valid)
        else $error("code 111 routed a channel");
    AST_RDATA_ONCE: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");

    COV_CONVERSION: cover property (conv_req_out.start ##[1:300] completion);
    COV_FLAG_CLEAR: cover property (done_flag_reg ##1 !done_flag_reg);
    COV_SET_BEATS_CLEAR: cover property (completion && reg_wr_in
        && reg_addr_in == ACR_OFS_STATUS);
    COV_LOCKED_WRITE: cover property (running && reg_wr_in
        && reg_addr_in == ACR_OFS_CONTROL);
endmodule // acr_control
`default_nettype wire

// [acr_conv_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Converter core stand-in
module acr_conv_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Control side
    input wire acr_pkg::acr_conv_req_t req_in,
    input wire logic [3:0] ticks_in,
    input wire logic [11:0] sample_in,
    // Answer
    output acr_pkg::acr_conv_res_t res_out
);
    import acr_pkg::*;
    logic busy_reg;
    logic [3:0] cnt_reg;
    // Data lines toggle outside the done pulse so a stale sample never looks valid
    always_ff @(posedge core_clk_in) begin
        res_out.done <= 1'b0;
        res_out.data <= ~res_out.data;
        if (!reset_n_in) begin
            busy_reg <= 1'b0;
            cnt_reg <= 4'h0;
            res_out.data <= 12'h5a5;
        end else if (req_in.start) begin
            busy_reg <= req_in.power_on;
            cnt_reg <= 4'h0;
        end else if (busy_reg && req_in.clk_tick) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg + 4'h1 == ticks_in) begin
                busy_reg <= 1'b0;
                res_out <= {1'b1, sample_in};
            end
        end
    end
endmodule // acr_conv_model
`default_nettype wire

// [acr_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Register-side converter control bench
module acr_control_test;
    import acr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic osc_in = 1'b0;
    logic osc_out = 1'b0;
    logic ir_en = 1'b0;
    logic sleep = 1'b0;
    logic wpin = 1'b0;
    logic wcmp = 1'b0;
    logic orst = 1'b0;
    logic [3:0] ticks = 4'h3;
    logic [11:0] sample = 12'h000;
    logic [7:0] rdata;
    logic [6:0] pin_an;
    logic ir_drv;
    logic rd_seen = 1'b0;
    acr_conv_req_t req;
    acr_conv_res_t res;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int total_checks = 0;
    const int divs[4] = '{16, 4, 64, 8};

    always #4 clk = ~clk;

    acr_control u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .conv_req_out(req), .conv_res_in(res), .osc_in_mode_in(osc_in),
        .osc_out_mode_in(osc_out), .infrared_output_enable_in(ir_en),
        .pin_analog_out(pin_an), .infrared_drive_out(ir_drv), .sleep_in(sleep),
        .wake_pin_change_in(wpin), .wake_comparator_in(wcmp), .other_reset_in(orst));

    acr_conv_model u_core (.core_clk_in(clk), .reset_n_in(rst_n), .req_in(req),
        .ticks_in(ticks), .sample_in(sample), .res_out(res));

    // ==========================================================
    // Shared tasks; every drive lands at a rising edge
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        rd_s <= 1'b0;
    endtask

    // Expected data is queued; the monitor below pairs it with the answer
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        wr_s <= 1'b0;
        rd_s <= 1'b1;
    endtask

    task automatic idle(input int n);
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        repeat (n - 1) @(posedge clk);
    endtask

    // Bounded wait on a one-cycle pulse seen at the falling edge
    task automatic wait_pulse(input bit tick, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((tick ? req.clk_tick : res.done) !== 1'b1 && n < 400);
        if (n >= 400) begin
            miscompares++;
            $display("wait limit reached");
            tally_and_finish();
        end
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_s;
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) check("read queue", 12'h1, 12'h0);
            else check("read data", 12'(rdata), 12'(exp_q.pop_front()));
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] t;
        logic [2:0] ch;
        logic [11:0] smp;
        logic s3;
        int r;
        int n;
        void'($urandom(32'h994fc4b8));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        idle(2);
        $display("test reset_values done");
        // Pin priority over every mode mix, all-ones and random selects
        v = 8'($urandom_range(127));
        for (int j = 0; j < 2; j++) begin
            wr(ACR_OFS_PIN_SELECT, j == 0 ? 8'hff : v);
            rd(ACR_OFS_PIN_SELECT, j == 0 ? 8'h7f : v);
            t = j == 0 ? 8'h7f : v;
            for (int i = 0; i < 8; i++) begin
                idle(1);
                osc_in <= i[2];
                osc_out <= i[1];
                ir_en <= i[0];
                @(negedge clk);
                check("pins", 12'(pin_an), 12'(t[6:0] & ~{i[2:1], 5'h00}));
                check("infrared", 12'(ir_drv), 12'(i[0] & ~t[4]));
            end
        end
        $display("test pin_select done");
        for (int c = 0; c < 4; c++) begin
            wr(ACR_OFS_CONTROL, {1'b0, c[1:0], 5'h00});
            // Two edges let a tick launched under the old divisor pass unseen
            idle(2);
            wait_pulse(1'b1, n);
            wait_pulse(1'b1, n);
            check("tick period", 12'(n), 12'(divs[c]));
        end
        $display("test divider done");
        for (int c = 0; c < 16; c++) begin
            wr(ACR_OFS_CONTROL, {4'h0, c[3:0]});
            idle(1);
            @(negedge clk);
            check("power", 12'(req.power_on), 12'(c[3]));
            check("channel", 12'(req.channel), 12'(c[2:0]));
            // Both oscillator modes are still on from the pin test
            check("channel valid", 12'(req.channel_valid), 12'(c[2:0] != 3'h7
                && !(osc_in && c[2:0] == 3'h6) && !(osc_out && c[2:0] == 3'h5)));
            rd(ACR_OFS_CONTROL, {4'h0, c[3:0]});
        end
        idle(1);
        $display("test channel_power done");
        // Conversions: trim off, saturating low, saturating high, random
        for (int k = 0; k < 4; k++) begin
            s3 = (k == 3);
            sleep <= s3;
            t = {k != 0, k == 2 ? 1'b1 : k == 1 ? 1'b0 : 1'($urandom),
                 (k == 1 || k == 2) ? 3'h7 : 3'($urandom), 3'($urandom)};
            smp = k == 1 ? 12'h009 : k == 2 ? 12'hff8 : 12'($urandom);
            sample <= smp;
            ch = 3'($urandom_range(6));
            r = int'(smp);
            if (t[7]) r = t[6] ? r + 2 * int'(t[5:3]) : r - 2 * int'(t[5:3]);
            if (r < 0) r = 0;
            if (r > 4095) r = 4095;
            wr(ACR_OFS_OFFSET_TRIM, t);
            rd(ACR_OFS_OFFSET_TRIM, t & 8'hf8);
            wr(ACR_OFS_CONTROL, {3'h1, 2'h3, ch});
            idle(1);
            @(negedge clk);
            check("start", 12'(req.start), 12'h001);
            @(negedge clk);
            check("start", 12'(req.start), 12'h000);
            wr(ACR_OFS_CONTROL, {3'h0, 2'h1, ~ch});
            // Divider field took the write; run stays set and channel stays locked
            rd(ACR_OFS_CONTROL, {3'h0, 2'h3, ch});
            idle(1);
            wait_pulse(1'b0, n);
            rd(ACR_OFS_RESULT_HIGH, 8'(r >> 8));
            rd(ACR_OFS_RESULT_LOW, 8'(r));
            rd(ACR_OFS_CONTROL, {3'h0, 2'h1, ch});
            rd(ACR_OFS_STATUS, {s3, 7'h01});
            wr(ACR_OFS_CONTROL, {3'h0, 2'h1, ~ch});
            wr(ACR_OFS_STATUS, {s3, 7'h01});
            rd(ACR_OFS_CONTROL, {3'h0, 2'h1, ch});
            rd(ACR_OFS_STATUS, {s3, 7'h01});
            wr(ACR_OFS_STATUS, 8'h00);
            wr(ACR_OFS_CONTROL, {3'h0, 2'h1, ~ch});
            rd(ACR_OFS_CONTROL, {3'h0, 2'h1, ~ch});
            rd(ACR_OFS_STATUS, {s3, 7'h00});
            idle(1);
        end
        $display("test conversion done");
        // Wake sources set the reset-type bit, any other reset clears it
        for (int i = 0; i < 4; i++) begin
            wpin <= (i == 0);
            wcmp <= (i == 2);
            orst <= i[0];
            @(posedge clk);
            wpin <= 1'b0;
            wcmp <= 1'b0;
            orst <= 1'b0;
            rd(ACR_OFS_STATUS, {~i[0], 7'h00});
            idle(1);
        end
        idle(2);
        $display("test reset_type done");
        tally_and_finish();
    end
endmodule // acr_control_test
`default_nettype wire
